// File: rtl/gpl_consts.vh
/*
 * constants of the general-purpose port block: register map, field
 * positions, reset values and implemented-bit masks of each port.
 * assumes an apb slave with a 12-bit byte address and 32-bit data.
 */
`ifndef GPL_CONSTS_VH
`define GPL_CONSTS_VH

// number of ports, and the ports with alternate functions
`define GPL_NPORT      4'd12
`define GPL_P10_LO     80
`define GPL_P11_LO     88

// register byte offsets; banks hold one word per port
`define GPL_OFS_DATA   12'h000
`define GPL_OFS_DIR    12'h040
`define GPL_OFS_BITOP  12'h080
`define GPL_OFS_ALT    12'h084
`define GPL_OFS_STAT   12'h088
`define GPL_OFS_MASK   12'h08c

// bit-operation register fields
`define GPL_BOP_BIT    2:0
`define GPL_BOP_PORT   7:4
`define GPL_BOP_OP     9:8
`define GPL_OP_NONE    2'h0
`define GPL_OP_SET     2'h1
`define GPL_OP_CLR     2'h2
`define GPL_OP_INV     2'h3

// pin positions of alternate functions inside port 10 and 11
`define GPL_TO_C       0
`define GPL_TO_A       4
`define GPL_TO_B       7
`define GPL_WAIT_BIT   0
`define GPL_CTX_A      4
`define GPL_CRX_A      5
`define GPL_CTX_B      6
`define GPL_CRX_B      7

// reset values
`define GPL_DIR_RST    8'hff
`define GPL_LAT_RST    8'h00
`define GPL_ALT_RST    8'h00
`define GPL_STAT_RST   8'h00
`define GPL_MASK_RST   8'hff
`define GPL_ZERO32     32'h0000_0000
`define GPL_ZERO8      8'h00
`define GPL_ONE8       8'h01

// implemented bits of each port
`define GPL_MASK_8     8'hff
`define GPL_MASK_7     8'h7f
`define GPL_MASK_6     8'h3f
`define GPL_MASK_5     8'h1f
`define GPL_MASK_4     8'h0f

`endif

// File: rtl/gpl_sync.v
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes the inputs come from pins outside the pclk domain.
 */
`timescale 1ns/100ps
module gpl_sync #(
    parameter W = 8
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    // first stage, read only by the second stage
    reg [W-1:0] meta_q;

    // both stages clear on reset, then follow the pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // gpl_sync

// File: rtl/gpl_port.v
/*
 * one 8-bit port: output latch, direction bits, pin synchroniser,
 * read value and pin drivers. unimplemented bits read and drive 0.
 * assumes write strobes are single-cycle pulses from the bus slave.
 */
`timescale 1ns/100ps
`include "gpl_consts.vh"
module gpl_port #(
    parameter [7:0] IMPL = 8'hff
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // pins
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out_q,
    output reg  [7:0] pin_oe_q,
    // register writes
    input  wire       lat_we,
    input  wire [7:0] lat_wd,
    input  wire       dir_we,
    input  wire [7:0] dir_wd,
    // alternate function overrides
    input  wire [7:0] alt_en,
    input  wire [7:0] alt_val,
    // state seen by the top
    output reg  [7:0] latch_q,
    output reg  [7:0] dir_q,
    output wire [7:0] pin_sync,
    output wire [7:0] rd_val
);

    // pins pass two flops before anything reads them
    gpl_sync #(.W(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pin_in),
        .q       (pin_sync)
    );

    // input bits read the pin, latch untouched
    assign rd_val = IMPL & ((dir_q & pin_sync) | (~dir_q & latch_q));

    // latch and direction registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= `GPL_LAT_RST & IMPL;
            dir_q   <= `GPL_DIR_RST & IMPL;
        end else begin
            if (lat_we) begin
                latch_q <= lat_wd & IMPL;
            end
            if (dir_we) begin
                dir_q <= dir_wd & IMPL;
            end
        end
    end

    // pin drivers, one cycle behind the latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= `GPL_ZERO8;
            pin_oe_q  <= `GPL_ZERO8;
        end else begin
            pin_out_q <= IMPL & ((latch_q & ~alt_en) | alt_val);
            pin_oe_q  <= IMPL & ~dir_q;
        end
    end

endmodule // gpl_port

// File: rtl/gpl_port_top.v
/*
 * general-purpose port block: twelve ports behind an apb slave,
 * bit set/clear/invert as 8-bit read-modify-write, port 0 level
 * change events with status, mask and interrupt, and alternate
 * functions of port 10 (key return, timer) and port 11 (wait, can).
 * assumes a single pclk domain; pins are asynchronous to it, the
 * timer and can controller signals are on pclk.
 */
`timescale 1ns/100ps
`include "gpl_consts.vh"

// Behaviour
// - output mode: write loads latch, pin drives
// - latch keeps value until next write
// - input mode: write loads latch, pin undriven
// - bit ops are full 8-bit read-modify-write
// - output mode read returns latch, unchanged
// - input mode read returns pin level
// - port 0 level change sets interrupt flag
// - register widths follow implemented port bits
module gpl_port_top (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // port pins, eight bits per port, port n at [8n+7:8n]
    input  wire [95:0] pin_in,
    output wire [95:0] pin_out,
    output wire [95:0] pin_oe,
    // timer outputs onto port 10
    input  wire        timer_output_a,
    input  wire        timer_output_b,
    input  wire        timer_output_c,
    // can transmit onto port 11
    input  wire        can_transmit_pin_a,
    input  wire        can_transmit_pin_b,
    // alternate inputs taken from pins
    output reg  [7:0]  key_return_in,
    output reg         wait_req_n,
    output reg         can_receive_pin_a,
    output reg         can_receive_pin_b,
    // interrupt
    output reg         irq
);

    // implemented bits of port n
    function [7:0] impl_mask;
        input integer n;
        begin
            case (n)
                1, 6:    impl_mask = `GPL_MASK_6;
                3:       impl_mask = `GPL_MASK_5;
                8:       impl_mask = `GPL_MASK_4;
                9:       impl_mask = `GPL_MASK_7;
                default: impl_mask = `GPL_MASK_8;
            endcase
        end
    endfunction

    // address hits a one-word-per-port bank
    function bank_hit;
        input [11:0] a;
        input [11:0] base;
        begin
            bank_hit = (a[11:6] == base[11:6]) && (a[5:2] < `GPL_NPORT);
        end
    endfunction

    // address hits a single register
    function reg_hit;
        input [11:0] a;
        input [11:0] base;
        begin
            reg_hit = (a[11:2] == base[11:2]);
        end
    endfunction

    // bus phase decode
    wire        setup  = psel & ~penable;
    wire        done   = psel & penable & pready;
    wire        wr     = done & pwrite;
    wire        rd     = done & ~pwrite;
    wire [3:0]  widx   = paddr[5:2];

    // per-port views gathered from the port slices
    wire [95:0] lat_w;                  // output latches
    wire [95:0] dir_w;                  // direction, 1 = input
    wire [95:0] sync_w;                 // synchronised pin levels
    wire [95:0] rdv_w;                  // value a read returns

    // control registers
    reg  [7:0]  alt_q;                  // alternate function select
    reg  [7:0]  stat_q;                 // sticky port 0 events
    reg  [7:0]  mask_q;                 // 1 masks the event
    reg  [7:0]  lvl_q;                  // last seen port 0 level

    // bit operation fields from the write data
    wire [3:0]  bop_port = pwdata[`GPL_BOP_PORT];
    wire [2:0]  bop_bit  = pwdata[`GPL_BOP_BIT];
    wire [1:0]  bop_op   = pwdata[`GPL_BOP_OP];
    wire [7:0]  bop_one  = `GPL_ONE8 << bop_bit;
    wire        bop_ok   = (bop_port < `GPL_NPORT) &&
                           (bop_op != `GPL_OP_NONE);
    wire        bop_wr   = wr & reg_hit(paddr, `GPL_OFS_BITOP) & bop_ok;
    reg  [7:0]  bop_cur;                // whole port as a read sees it
    reg  [7:0]  bop_res;                // port after the bit change

    // alternate function overrides of the pin drivers
    reg  [95:0] alt_en_w;
    reg  [95:0] alt_val_w;

    // read data and error decided at the setup phase
    reg  [31:0] rd_d;
    reg         err_d;

    // read whole port, change one bit
    always @* begin
        bop_cur = `GPL_ZERO8;
        if (bop_port < `GPL_NPORT) begin
            bop_cur = rdv_w[{bop_port, 3'b000} +: 8];
        end
        case (bop_op)
            `GPL_OP_SET: bop_res = bop_cur | bop_one;
            `GPL_OP_CLR: bop_res = bop_cur & ~bop_one;
            `GPL_OP_INV: bop_res = bop_cur ^ bop_one;
            default:     bop_res = bop_cur;
        endcase
    end

    // alternate outputs merged into the port 10 and 11 drivers
    always @* begin
        alt_en_w  = {96{1'b0}};
        alt_val_w = {96{1'b0}};
        // timer outputs or onto a zero latch
        alt_val_w[`GPL_P10_LO + `GPL_TO_C] = timer_output_c;
        alt_val_w[`GPL_P10_LO + `GPL_TO_A] = timer_output_a;
        alt_val_w[`GPL_P10_LO + `GPL_TO_B] = timer_output_b;
        alt_en_w[`GPL_P11_LO + `GPL_CTX_A]  = alt_q[`GPL_CTX_A];
        alt_en_w[`GPL_P11_LO + `GPL_CRX_A]  = alt_q[`GPL_CRX_A];
        alt_en_w[`GPL_P11_LO + `GPL_CTX_B]  = alt_q[`GPL_CTX_B];
        alt_en_w[`GPL_P11_LO + `GPL_CRX_B]  = alt_q[`GPL_CRX_B];
        alt_val_w[`GPL_P11_LO + `GPL_CTX_A] = alt_q[`GPL_CTX_A] &
                                              can_transmit_pin_a;
        alt_val_w[`GPL_P11_LO + `GPL_CTX_B] = alt_q[`GPL_CTX_B] &
                                              can_transmit_pin_b;
    end

    // one slice per port; write strobes decoded here
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_port
            localparam [3:0] PN = gi;
            // data write to this port's word
            wire dat_we = wr & bank_hit(paddr, `GPL_OFS_DATA) &
                          (widx == PN);
            // bit operation aimed at this port
            wire bit_we = bop_wr & (bop_port == PN);
            // direction write
            wire dir_we = wr & bank_hit(paddr, `GPL_OFS_DIR) &
                          (widx == PN);
            wire [7:0] lat_wd = bit_we ? bop_res : pwdata[7:0];

            gpl_port #(.IMPL(impl_mask(gi))) u_port (
                .pclk      (pclk),
                .presetn   (presetn),
                .pin_in    (pin_in[8*gi +: 8]),
                .pin_out_q (pin_out[8*gi +: 8]),
                .pin_oe_q  (pin_oe[8*gi +: 8]),
                .lat_we    (dat_we | bit_we),
                .lat_wd    (lat_wd),
                .dir_we    (dir_we),
                .dir_wd    (pwdata[7:0]),
                .alt_en    (alt_en_w[8*gi +: 8]),
                .alt_val   (alt_val_w[8*gi +: 8]),
                .latch_q   (lat_w[8*gi +: 8]),
                .dir_q     (dir_w[8*gi +: 8]),
                .pin_sync  (sync_w[8*gi +: 8]),
                .rd_val    (rdv_w[8*gi +: 8])
            );
        end
    endgenerate

    // read multiplexer; unmapped addresses answer with an error
    always @* begin
        rd_d  = `GPL_ZERO32;
        err_d = 1'b0;
        if (bank_hit(paddr, `GPL_OFS_DATA)) begin
            rd_d[7:0] = rdv_w[{widx, 3'b000} +: 8];
        end else if (bank_hit(paddr, `GPL_OFS_DIR)) begin
            rd_d[7:0] = dir_w[{widx, 3'b000} +: 8];
        end else if (reg_hit(paddr, `GPL_OFS_BITOP)) begin
            // write-only trigger, reads as zero
            rd_d = `GPL_ZERO32;
        end else if (reg_hit(paddr, `GPL_OFS_ALT)) begin
            rd_d[7:0] = alt_q;
        end else if (reg_hit(paddr, `GPL_OFS_STAT)) begin
            rd_d[7:0] = stat_q;
        end else if (reg_hit(paddr, `GPL_OFS_MASK)) begin
            rd_d[7:0] = mask_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // apb answer: ready in the first access cycle, data taken at setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `GPL_ZERO32;
        end else begin
            // a request held for more cycles cannot see ready twice
            pready <= setup;
            // error stands only beside its ready pulse
            pslverr <= setup & err_d;
            if (setup) begin
                prdata  <= pwrite ? `GPL_ZERO32 : rd_d;
            end
        end
    end

    // alternate function select and event mask, written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_q  <= `GPL_ALT_RST;
            mask_q <= `GPL_MASK_RST;
        end else begin
            if (wr & reg_hit(paddr, `GPL_OFS_ALT)) begin
                alt_q <= pwdata[7:0];
            end
            if (wr & reg_hit(paddr, `GPL_OFS_MASK)) begin
                mask_q <= pwdata[7:0];
            end
        end
    end

    // port 0 level as the interrupt input sees it: the latch where
    // the pin is driven, the synchronised pin where it is not
    wire [7:0] lvl0 = rdv_w[7:0];
    wire [7:0] ev0  = lvl0 ^ lvl_q;

    // sticky events; a read clears only the bits it returned, so an
    // event in the clearing cycle survives
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q  <= `GPL_ZERO8;
            stat_q <= `GPL_STAT_RST;
            irq    <= 1'b0;
        end else begin
            lvl_q <= lvl0;
            if (rd & reg_hit(paddr, `GPL_OFS_STAT)) begin
                stat_q <= (stat_q & ~prdata[7:0]) | ev0;
            end else begin
                stat_q <= stat_q | ev0;
            end
            irq <= |(stat_q & ~mask_q);
        end
    end

    // alternate inputs handed to the peripherals
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_return_in     <= `GPL_ZERO8;
            wait_req_n        <= 1'b1;
            can_receive_pin_a <= 1'b1;
            can_receive_pin_b <= 1'b1;
        end else begin
            // only input-mode bits reach key return
            key_return_in <= sync_w[`GPL_P10_LO +: 8] &
                             dir_w[`GPL_P10_LO +: 8];
            // wait needs select and input mode
            if (alt_q[`GPL_WAIT_BIT] &
                dir_w[`GPL_P11_LO + `GPL_WAIT_BIT]) begin
                wait_req_n <= sync_w[`GPL_P11_LO + `GPL_WAIT_BIT];
            end else begin
                wait_req_n <= 1'b1;
            end
            if (alt_q[`GPL_CRX_A]) begin
                can_receive_pin_a <= sync_w[`GPL_P11_LO + `GPL_CRX_A];
            end else begin
                can_receive_pin_a <= 1'b1;
            end
            if (alt_q[`GPL_CRX_B]) begin
                can_receive_pin_b <= sync_w[`GPL_P11_LO + `GPL_CRX_B];
            end else begin
                can_receive_pin_b <= 1'b1;
            end
        end
    end

    // latch view kept for completeness of the slice ports
    wire unused_lat = |lat_w;

endmodule // gpl_port_top

// File: testbench/gpl_port_top_sva.sv
/*
 * checker for the general-purpose port block: apb answer timing,
 * latch, pin drive and read-back relations seen on port 2 and port 3.
 * assumes one pclk domain and the register map of gpl_consts.vh.
 */
`timescale 1ns/100ps
module gpl_port_top_sva (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic [95:0] pin_in,
    input wire logic [95:0] pin_out,
    input wire logic [95:0] pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       hs;      // completed transfer
    logic       lat_wr;  // anything that may load the port 2 latch
    logic [15:0] prev_q; // last port 2 pin level and enable
    logic [3:0]  cnt_q;  // edges port 2 pins have been quiet
    assign hs = psel && penable && pready;
    assign lat_wr = hs && pwrite && (paddr == 12'h008 || (paddr == 12'h080 && pwdata[7:4] == 4'h2));

    // quiet counter: a read only sees the pin once the synchroniser settled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 16'h0000;
            cnt_q  <= 4'h0;
        end else begin
            prev_q <= {pin_in[23:16], pin_oe[23:16]};
            cnt_q  <= ({pin_in[23:16], pin_oe[23:16]} != prev_q) ? 4'h0 : (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1);
        end
    end

    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_setbit2;
        hs && pwrite && paddr == 12'h080 && pwdata[9:8] == 2'h1 && pwdata[7:4] == 4'h2 && !pwdata[2]
            && pin_oe[19:16] == 4'hf;
    endsequence

    chk_apb_one_wait: assert property ((psel && !penable) |=> s_answer)
        else $error("pready not a single pulse one cycle after setup");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_write_drives_pin: assert property (
        (hs && pwrite && paddr == 12'h008 && pin_oe[23:16] == 8'hff) |=> ##1 pin_out[23:16] == $past(pwdata[7:0], 2))
        else $error("output pin does not show written value");
    chk_latch_holds: assert property (
        (pin_oe[23:16] == 8'hff && !$past(lat_wr)) |=> ($stable(pin_out[23:16]) || pin_oe[23:16] != 8'hff))
        else $error("output pin changed without a write");
    chk_oe_only_dir: assert property (
        $changed(pin_oe[23:16]) |-> $past(hs && pwrite && paddr == 12'h048, 2))
        else $error("pin enable changed without direction write");
    chk_bitop_rmw: assert property (
        s_setbit2 |=> ##1 pin_out[19:16] == ($past(pin_out[19:16]) | (4'h1 << $past(pwdata[1:0], 2))))
        else $error("bit set did not keep other bits");
    chk_read_latch: assert property (
        (pready && !pwrite && paddr == 12'h008 && pin_oe[23:16] == 8'hff) |-> prdata[7:0] == pin_out[23:16])
        else $error("output mode read differs from latch");
    chk_read_pin: assert property (
        (pready && !pwrite && paddr == 12'h008 && pin_oe[23:16] == 8'h00 && cnt_q > 4'h5)
            |-> prdata[7:0] == pin_in[23:16])
        else $error("input mode read differs from pin");
    chk_width_read: assert property (
        (pready && !pwrite && paddr == 12'h04c) |-> prdata[31:5] == 27'h0)
        else $error("port 3 direction reads unimplemented bits");
    chk_width_pins: assert property (
        pin_oe[31:29] == 3'h0 && pin_oe[71:68] == 4'h0)
        else $error("unimplemented pin enabled");
endmodule // gpl_port_top_sva

bind gpl_port_top gpl_port_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// File: testbench/gpl_pin_model.sv
/*
 * far side of the port pins: a driven pin reads back its own level,
 * an undriven pin shows what the outside world puts on it.
 * assumes ext_lvl is set by the bench for released pins.
 */
`timescale 1ns/100ps
module gpl_pin_model (
    // from the block
    input  wire logic [95:0] pin_out,
    input  wire logic [95:0] pin_oe,
    // outside world
    input  wire logic [95:0] ext_lvl,
    // back to the block
    output wire logic [95:0] pin_in
);
    // released pins never echo the old drive, so stale latch values cannot pass reads
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpl_pin_model

// File: testbench/gpl_port_top_tb.sv
/*
 * self-checking bench of the general-purpose port block over apb.
 * assumes the pin model closes the pin loop and 250 MHz pclk.
 */
`timescale 1ns/100ps
module gpl_port_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [95:0] ext_lvl = 96'h0;     // outside levels on released pins
    logic        tmr_a = 1'b0;        // timer output toward port 10
    logic        ctx_a = 1'b0;        // can transmit toward port 11
    wire  [31:0] prdata;
    wire         pready, pslverr, wait_req_n, crx_a, crx_b, irq;
    wire  [7:0]  key_return_in;
    wire  [95:0] pin_in, pin_out, pin_oe;
    logic [31:0] rv;                  // last read data
    logic        er;                  // last error response
    int          fail_count = 0;
    int          total_checks = 0;

    gpl_port_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .timer_output_a(tmr_a), .timer_output_b(1'b0),
        .timer_output_c(1'b0), .can_transmit_pin_a(ctx_a), .can_transmit_pin_b(1'b0),
        .key_return_in(key_return_in), .wait_req_n(wait_req_n), .can_receive_pin_a(crx_a),
        .can_receive_pin_b(crx_b), .irq(irq));
    gpl_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

    // 4 ns clock
    always #2 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // one apb transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rv);
    endtask

    task automatic t_regs();
        rdc("dir0", 12'h040, 32'h0000_00ff);
        wr(12'h04c, 32'h0000_00ff);
        rdc("dir3", 12'h04c, 32'h0000_001f);
        rdc("mask", 12'h08c, 32'h0000_00ff);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        $display("test regs done");
    endtask

    task automatic t_out();
        wr(12'h048, 32'h0);
        wr(12'h008, 32'h0000_00a5);
        repeat (2) @(posedge pclk);
        chk("pin2", 32'ha5, {24'h0, pin_out[23:16]});
        repeat (6) @(posedge pclk);
        rdc("rd2", 12'h008, 32'h0000_00a5);
        chk("pin2 kept", 32'ha5, {24'h0, pin_out[23:16]});
        $display("test output done");
    endtask

    task automatic t_in();
        ext_lvl[23:16] <= 8'h3c;
        wr(12'h048, 32'h0000_00ff);
        wr(12'h008, 32'h0000_0055);
        repeat (4) @(posedge pclk);
        chk("oe2", 32'h0, {24'h0, pin_oe[23:16]});
        rdc("rd2 pin", 12'h008, 32'h0000_003c);
        wr(12'h048, 32'h0);
        repeat (2) @(posedge pclk);
        chk("pin2 latch", 32'h55, {24'h0, pin_out[23:16]});
        $display("test input done");
    endtask

    task automatic t_bitop();
        logic [1:0] op [3] = '{2'h1, 2'h2, 2'h3};
        logic [2:0] bn [3] = '{3'h1, 3'h1, 3'h0};
        logic [3:0] ex [3] = '{4'h2, 4'h0, 4'h1};
        ext_lvl[23:16] <= 8'ha0;
        wr(12'h048, 32'h0000_00f0);
        wr(12'h008, 32'h0);
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            wr(12'h080, {22'h0, op[i], 4'h2, 1'b0, bn[i]});
            repeat (2) @(posedge pclk);
            chk("bitop", {28'h0, ex[i]}, {28'h0, pin_out[19:16]});
        end
        // an operation code of zero is refused, latch keeps its value
        wr(12'h080, 32'h0000_0021);
        wr(12'h048, 32'h0);
        repeat (2) @(posedge pclk);
        chk("rmw latch", 32'ha1, {24'h0, pin_out[23:16]});
        $display("test bitop done");
    endtask

    task automatic t_irq();
        apb(1'b0, 12'h088, 32'h0);
        // masked before port 0 becomes an output
        wr(12'h08c, 32'h0000_00ff);
        wr(12'h040, 32'h0000_00fe);
        wr(12'h000, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc("stat", 12'h088, 32'h0000_0001);
        rdc("stat clr", 12'h088, 32'h0);
        wr(12'h08c, 32'h0000_00fe);
        wr(12'h000, 32'h0);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("stat2", 12'h088, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
        $display("test irq done");
    endtask

    task automatic t_alt();
        ext_lvl[87:80] <= 8'h5a;
        repeat (4) @(posedge pclk);
        chk("keyret", 32'h5a, {24'h0, key_return_in});
        wr(12'h068, 32'h0000_00ef);
        wr(12'h028, 32'h0);
        tmr_a <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("timer", 32'h3, {30'h0, pin_out[84], pin_oe[84]});
        wr(12'h084, 32'h0000_00f1);
        wr(12'h06c, 32'h0000_00a1);
        ext_lvl[93] <= 1'b0;
        ext_lvl[88] <= 1'b0;
        // can controller starts sending only after the select
        ctx_a <= 1'b1;
        tmr_a <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("alt", 32'h8, {28'h0, pin_out[92], wait_req_n, crx_a, crx_b});
        chk("timer off", 32'h0, {31'h0, pin_out[84]});
        $display("test alt done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the under two hundred cycles of the tests
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_bitop();
        t_irq();
        t_alt();
        end_sim();
    end
endmodule // gpl_port_top_tb
